/* logic/nsl_pkg.sv */
package nsl_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_ADDR   = 8'h1C;
	localparam logic [7:0] OFS_LOCK   = 8'h20;
	localparam logic [7:0] OFS_IFLAG  = 8'h24;
	localparam logic [7:0] OFS_IMASK  = 8'h28;
	localparam logic [7:0] OFS_CTRL   = 8'h2C;
	localparam logic [7:0] OFS_CMD    = 8'h30;

	// status field positions
	localparam int unsigned ST_SEC    = 8;
	localparam int unsigned ST_CFAIL  = 4;
	localparam int unsigned ST_LOCKW  = 3;
	localparam int unsigned ST_BADCMD = 2;
	localparam int unsigned ST_LOAD   = 1;
	localparam int unsigned ST_PRM    = 0;

	// interrupt flag positions, same layout in the mask
	localparam int unsigned IF_READY = 0;
	localparam int unsigned IF_ERROR = 1;

	// control fields
	localparam int unsigned CTRL_MANUAL_WRITE_SETTING   = 7;
	localparam int unsigned CTRL_SLP_LO = 8;

	// command word: code in low bits, key above it
	localparam int unsigned CMD_KEY_LO = 8;
	localparam int unsigned REGION_LO  = 18;

	// values after reset
	localparam logic [15:0] LOCK_RST = 16'hFFFF;
	localparam logic        MANUAL_WRITE_SETTING_RST = 1'h1;
	localparam logic [1:0]  SLP_RST  = 2'h0;
	localparam logic [21:0] ADDR_RST = 22'h000000;

	// sleep power reduction settings
	localparam logic [1:0] SLP_WAKE_ACCESS  = 2'h0;
	localparam logic [1:0] SLP_WAKE_INSTANT = 2'h1;
	localparam logic [1:0] SLP_DISABLED     = 2'h3;

	// command codes and key (values arbitrary)
	localparam logic [6:0] CMD_ERASE_ROW   = 7'h01;
	localparam logic [6:0] CMD_WRITE_PAGE  = 7'h02;
	localparam logic [6:0] CMD_LOCK        = 7'h03;
	localparam logic [6:0] CMD_UNLOCK      = 7'h04;
	localparam logic [6:0] CMD_SET_PRM     = 7'h05;
	localparam logic [6:0] CMD_CLR_PRM     = 7'h06;
	localparam logic [6:0] CMD_PBUF_CLR    = 7'h07;
	localparam logic [6:0] CMD_ERASE_LOCKS = 7'h08;
	localparam logic [7:0] CMD_KEY         = 8'h3C;

	typedef enum logic [0:0] {NSL_IDLE, NSL_BUSY} nsl_fsm_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} nsl_bus_t;

	typedef struct packed {
		logic        start;
		logic        erase;
		logic [21:0] addr;
	} nsl_nvm_req_t;

	typedef struct packed {
		logic        load;
		logic        last;
		logic [21:0] addr;
	} nsl_pbuf_t;

	typedef struct packed {
		nsl_fsm_t     fsm;
		logic         ready;
		logic         cfail;
		logic         lockw;
		logic         badcmd;
		logic         load;
		logic         power_reduced_state;
		logic         sec;
		logic [21:0]  addr;
		logic [15:0]  lock;
		logic         manual_write_setting;
		logic [1:0]   slp;
		logic [1:0]   iflag;
		logic [1:0]   imask;
		logic         irq;
		logic [31:0]  rdata;
		nsl_nvm_req_t req;
	} nsl_state_t;

endpackage : nsl_pkg

/* logic/nsl_core.sv */
`timescale 1ns/1ps

module nsl_core (
	input  wire logic                  core_clk_i,      // 200 MHz
	input  wire logic                  srst_i,          // sync reset
	input  wire nsl_pkg::nsl_bus_t     bus_i,           // register access
	output logic [31:0]                rdata_o,         // read data
	output nsl_pkg::nsl_nvm_req_t      nvm_req_o,       // array command
	input  wire logic                  nvm_done_i,      // array op done
	input  wire logic                  nvm_fail_i,      // array op failed
	input  wire nsl_pkg::nsl_pbuf_t    pbuf_i,          // buffer load
	input  wire logic                  array_access_i,  // bus read of array
	input  wire logic                  sleep_enter_i,   // sleep entry pulse
	input  wire logic                  sleep_exit_i,    // sleep exit pulse
	input  wire logic                  security_i,      // security setting
	output logic                       ready_o,         // controller ready
	output logic                       power_reduced_o, // power reduced
	output logic [15:0]                region_lock_o,   // 1 = unlocked
	output logic                       irq_o            // interrupt level
);

	nsl_pkg::nsl_state_t s_r;
	nsl_pkg::nsl_state_t s_nxt;

	// command decode terms, shared with the checks below
	logic        cmd_wr;
	logic        cmd_ok;
	logic [6:0]  cmd_code;
	logic        sw_go;
	logic        auto_go;
	logic        lock_hit;
	logic        set_prm_cmd;
	logic        lock_cmd;
	logic        err_any;

	function automatic logic [3:0] nsl_region(input logic [21:0] a);
		return a[nsl_pkg::REGION_LO +: 4];
	endfunction : nsl_region

	function automatic logic nsl_known(input logic [6:0] c);
		return (c >= nsl_pkg::CMD_ERASE_ROW) &&
			(c <= nsl_pkg::CMD_ERASE_LOCKS);
	endfunction : nsl_known

	// next-state logic for the whole block
	always_comb begin
		logic [21:0] tgt;
		logic        do_wr;
		logic        do_er;
		logic        clr_load;
		logic        set_lockw;
		logic        set_bad;
		logic        set_fail;
		logic        set_prm;
		logic        clr_prm;
		logic [31:0] wd;
		tgt = s_r.addr;
		do_wr = 1'b0;
		do_er = 1'b0;
		clr_load = 1'b0;
		set_lockw = 1'b0;
		set_bad = 1'b0;
		set_fail = 1'b0;
		set_prm = 1'b0;
		clr_prm = 1'b0;
		wd = bus_i.wdata;
		s_nxt = s_r;
		s_nxt.req.start = 1'b0;
		s_nxt.rdata = 32'h00000000;
		s_nxt.sec = security_i;
		cmd_wr = bus_i.wr && (bus_i.addr == nsl_pkg::OFS_CMD);
		cmd_code = wd[6:0];
		cmd_ok = nsl_known(cmd_code) &&
			(wd[nsl_pkg::CMD_KEY_LO +: 8] == nsl_pkg::CMD_KEY);
		set_prm_cmd = 1'b0;
		lock_cmd = 1'b0;
		sw_go = 1'b0;
		auto_go = 1'b0;
		// bad code or key is flagged even while busy
		if (cmd_wr && !cmd_ok) begin
			set_bad = 1'b1;
		end else if (cmd_wr) begin
			case (cmd_code)
				nsl_pkg::CMD_WRITE_PAGE: begin
					do_wr = (s_r.fsm == nsl_pkg::NSL_IDLE);
				end
				nsl_pkg::CMD_ERASE_ROW: begin
					do_er = (s_r.fsm == nsl_pkg::NSL_IDLE);
				end
				nsl_pkg::CMD_LOCK: begin
					s_nxt.lock[nsl_region(s_r.addr)] = 1'b0;
					lock_cmd = 1'b1;
				end
				nsl_pkg::CMD_UNLOCK: begin
					s_nxt.lock[nsl_region(s_r.addr)] = 1'b1;
					lock_cmd = 1'b1;
				end
				nsl_pkg::CMD_ERASE_LOCKS: begin
					s_nxt.lock = nsl_pkg::LOCK_RST;
					lock_cmd = 1'b1;
				end
				nsl_pkg::CMD_SET_PRM: begin
					set_prm = 1'b1;
					set_prm_cmd = 1'b1;
				end
				nsl_pkg::CMD_CLR_PRM: begin
					clr_prm = 1'b1;
				end
				nsl_pkg::CMD_PBUF_CLR: begin
					clr_load = 1'b1;
				end
				default: begin
					set_bad = 1'b1;
				end
			endcase
		end
		sw_go = do_wr || do_er;
		// automatic page write; a software command in the same cycle wins
		if (pbuf_i.load && pbuf_i.last && !s_r.manual_write_setting && !cmd_wr &&
			(s_r.fsm == nsl_pkg::NSL_IDLE)) begin
			do_wr = 1'b1;
			auto_go = 1'b1;
			tgt = pbuf_i.addr;
		end
		// launch towards the array unless the region is locked
		lock_hit = (do_wr || do_er) && !s_r.lock[nsl_region(tgt)];
		if (lock_hit) begin
			set_lockw = 1'b1;
		end else if (do_wr || do_er) begin
			s_nxt.req.start = 1'b1;
			s_nxt.req.erase = do_er;
			s_nxt.req.addr = tgt;
			s_nxt.fsm = nsl_pkg::NSL_BUSY;
			s_nxt.ready = 1'b0;
		end
		if (do_wr) begin
			clr_load = 1'b1;
		end
		// array completion
		case (s_r.fsm)
			nsl_pkg::NSL_IDLE: begin
				s_nxt.ready = !s_nxt.req.start;
			end
			nsl_pkg::NSL_BUSY: begin
				if (nvm_done_i) begin
					s_nxt.fsm = nsl_pkg::NSL_IDLE;
					s_nxt.ready = 1'b1;
				end
			end
			default: begin
				s_nxt.fsm = nsl_pkg::NSL_IDLE;
			end
		endcase
		set_fail = nvm_fail_i;
		// software register writes; clears go first so sets win
		if (bus_i.wr) begin
			case (bus_i.addr)
				nsl_pkg::OFS_STATUS: begin
					if (wd[nsl_pkg::ST_CFAIL]) s_nxt.cfail = 1'b0;
					if (wd[nsl_pkg::ST_LOCKW]) s_nxt.lockw = 1'b0;
					if (wd[nsl_pkg::ST_BADCMD]) s_nxt.badcmd = 1'b0;
					if (wd[nsl_pkg::ST_LOAD]) s_nxt.load = 1'b0;
				end
				nsl_pkg::OFS_ADDR: s_nxt.addr = wd[21:0];
				nsl_pkg::OFS_IFLAG: s_nxt.iflag = s_nxt.iflag & ~wd[1:0];
				nsl_pkg::OFS_IMASK: s_nxt.imask = wd[1:0];
				nsl_pkg::OFS_CTRL: begin
					s_nxt.manual_write_setting = wd[nsl_pkg::CTRL_MANUAL_WRITE_SETTING];
					s_nxt.slp = wd[nsl_pkg::CTRL_SLP_LO +: 2];
				end
				default: ;
			endcase
		end
		// ready event after the software clear, so a finish is never lost
		if (s_r.fsm == nsl_pkg::NSL_BUSY && nvm_done_i) begin
			s_nxt.iflag[nsl_pkg::IF_READY] = 1'b1;
		end
		// hardware may overwrite a software address write
		if (pbuf_i.load) begin
			s_nxt.addr = pbuf_i.addr;
		end
		// load flag: hardware clear, then set (set wins)
		if (clr_load) s_nxt.load = 1'b0;
		if (pbuf_i.load) s_nxt.load = 1'b1;
		// sticky error flags
		if (set_fail) s_nxt.cfail = 1'b1;
		if (set_lockw) s_nxt.lockw = 1'b1;
		if (set_bad) s_nxt.badcmd = 1'b1;
		err_any = set_fail || set_lockw || set_bad;
		if (err_any) s_nxt.iflag[nsl_pkg::IF_ERROR] = 1'b1;
		// power reduction: leaving first, entering wins
		if (array_access_i || (sleep_exit_i &&
			s_r.slp == nsl_pkg::SLP_WAKE_INSTANT)) begin
			clr_prm = 1'b1;
		end
		if (sleep_enter_i && s_r.slp != nsl_pkg::SLP_DISABLED) begin
			set_prm = 1'b1;
		end
		if (clr_prm) s_nxt.power_reduced_state = 1'b0;
		if (set_prm) s_nxt.power_reduced_state = 1'b1;
		s_nxt.irq = |(s_nxt.iflag & s_nxt.imask);
		// read mux; unused bits stay zero
		if (bus_i.rd) begin
			case (bus_i.addr)
				nsl_pkg::OFS_STATUS: begin
					s_nxt.rdata[nsl_pkg::ST_SEC] = s_r.sec;
					s_nxt.rdata[nsl_pkg::ST_CFAIL] = s_r.cfail;
					s_nxt.rdata[nsl_pkg::ST_LOCKW] = s_r.lockw;
					s_nxt.rdata[nsl_pkg::ST_BADCMD] = s_r.badcmd;
					s_nxt.rdata[nsl_pkg::ST_LOAD] = s_r.load;
					s_nxt.rdata[nsl_pkg::ST_PRM] = s_r.power_reduced_state;
				end
				nsl_pkg::OFS_ADDR: s_nxt.rdata[21:0] = s_r.addr;
				nsl_pkg::OFS_LOCK: s_nxt.rdata[15:0] = s_r.lock;
				nsl_pkg::OFS_IFLAG: s_nxt.rdata[1:0] = s_r.iflag;
				nsl_pkg::OFS_IMASK: s_nxt.rdata[1:0] = s_r.imask;
				nsl_pkg::OFS_CTRL: begin
					s_nxt.rdata[nsl_pkg::CTRL_MANUAL_WRITE_SETTING] = s_r.manual_write_setting;
					s_nxt.rdata[nsl_pkg::CTRL_SLP_LO +: 2] = s_r.slp;
				end
				nsl_pkg::OFS_CMD: begin
					s_nxt.rdata[0] = s_r.fsm == nsl_pkg::NSL_BUSY;
				end
				default: ;
			endcase
		end
	end

	// state register; every region starts unlocked
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			s_r <= '0;
			s_r.ready <= 1'b1;
			s_r.lock <= nsl_pkg::LOCK_RST;
			s_r.manual_write_setting <= nsl_pkg::MANUAL_WRITE_SETTING_RST;
			s_r.slp <= nsl_pkg::SLP_RST;
			s_r.addr <= nsl_pkg::ADDR_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state flops
	assign rdata_o = s_r.rdata;
	assign nvm_req_o = s_r.req;
	assign ready_o = s_r.ready;
	assign power_reduced_o = s_r.power_reduced_state;
	assign region_lock_o = s_r.lock;
	assign irq_o = s_r.irq;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);
	property p_busy_not_ready;
		s_r.fsm == nsl_pkg::NSL_BUSY && !nvm_done_i |->
			!ready_o ##1 !ready_o;
	endproperty
	a_busy_not_ready: assert property (p_busy_not_ready)
		else $error("ready high during array operation");
	property p_sec_copy;
		bus_i.rd && bus_i.addr == nsl_pkg::OFS_STATUS |=>
			rdata_o[8] == $past(security_i, 2);
	endproperty
	a_sec_copy: assert property (p_sec_copy)
		else $error("security bit not mirrored");
	property p_fail_sticky;
		nvm_fail_i |=> s_r.cfail [*3] or
			(s_r.cfail ##[1:2] $fell(s_r.cfail));
	endproperty
	a_fail_sticky: assert property (p_fail_sticky)
		else $error("failure flag not latched");
	property p_lock_hit;
		lock_hit |=> s_r.lockw && !nvm_req_o.start;
	endproperty
	a_lock_hit: assert property (p_lock_hit)
		else $error("locked region write not refused");
	property p_bad_cmd;
		cmd_wr && !cmd_ok |=> s_r.badcmd && !nvm_req_o.start;
	endproperty
	a_bad_cmd: assert property (p_bad_cmd)
		else $error("bad command not flagged");
	property p_w1c_zero;
		bus_i.wr && bus_i.addr == nsl_pkg::OFS_STATUS &&
			!bus_i.wdata[nsl_pkg::ST_LOCKW] && s_r.lockw |=> s_r.lockw;
	endproperty
	a_w1c_zero: assert property (p_w1c_zero)
		else $error("zero write cleared a flag");
	property p_load_set;
		pbuf_i.load |=> s_r.load;
	endproperty
	a_load_set: assert property (p_load_set)
		else $error("load flag not set");
	property p_prm_set;
		set_prm_cmd |=> power_reduced_o;
	endproperty
	a_prm_set: assert property (p_prm_set)
		else $error("power reduction not entered");
	property p_prm_clr;
		array_access_i && !set_prm_cmd && !sleep_enter_i |=>
			!power_reduced_o;
	endproperty
	a_prm_clr: assert property (p_prm_clr)
		else $error("power reduction not left on access");
	property p_cmd_addr;
		sw_go && !lock_hit |=> nvm_req_o.addr == $past(s_r.addr);
	endproperty
	a_cmd_addr: assert property (p_cmd_addr)
		else $error("array address not from address register");
	property p_addr_load;
		pbuf_i.load |=> s_r.addr == $past(pbuf_i.addr);
	endproperty
	a_addr_load: assert property (p_addr_load)
		else $error("address not updated on load");
	property p_lock_ro;
		!lock_cmd |=> $stable(region_lock_o);
	endproperty
	a_lock_ro: assert property (p_lock_ro)
		else $error("lock bits changed without command");
	property p_lock_erase;
		lock_cmd && cmd_code == nsl_pkg::CMD_ERASE_LOCKS |=>
			region_lock_o == 16'hFFFF;
	endproperty
	a_lock_erase: assert property (p_lock_erase)
		else $error("lock erase left a region locked");
	property p_err_flag;
		err_any |=> s_r.iflag[1] ##0 (irq_o == s_r.imask[1] || s_r.irq);
	endproperty
	a_err_flag: assert property (p_err_flag)
		else $error("error interrupt flag not raised");
	property p_auto_write;
		auto_go && !lock_hit |=> nvm_req_o.start && !nvm_req_o.erase;
	endproperty
	a_auto_write: assert property (p_auto_write)
		else $error("auto page write not started");
	property p_rsv_zero;
		bus_i.rd && bus_i.addr == nsl_pkg::OFS_STATUS |=>
			rdata_o[31:9] == 23'h000000 && rdata_o[7:5] == 3'h0;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("reserved status bits not zero");

	c_page_write: cover property (nvm_req_o.start ##[1:50] nvm_done_i);
	c_lock_refuse: cover property (lock_hit);
	c_auto_write: cover property (auto_go ##1 nvm_req_o.start);
	c_irq: cover property (err_any ##[1:4] irq_o);

endmodule : nsl_core

/* tb/nsl_flash_model.sv */
`timescale 1ns/1ps

module nsl_flash_model (
	input  wire logic                  core_clk_i, // 200 MHz
	input  wire logic                  srst_i,     // sync reset
	input  wire nsl_pkg::nsl_nvm_req_t req_i,      // launch from controller
	input  wire logic [3:0]            dly_i,      // busy cycles per op, minus one
	input  wire logic                  fail_en_i,  // report a failure
	output logic                       done_o,     // op finished pulse
	output logic                       fail_o      // op failed pulse
);
	logic [3:0] cnt_r;
	logic       busy_r;

	// one op at a time; done and fail are single-cycle pulses, low otherwise
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			busy_r <= 1'h0;
			cnt_r  <= 4'h0;
			done_o <= 1'h0;
			fail_o <= 1'h0;
		end else begin
			done_o <= 1'h0;
			fail_o <= 1'h0;
			if (req_i.start) begin
				busy_r <= 1'h1;
				cnt_r  <= dly_i;
			end else if (busy_r) begin
				if (cnt_r == 4'h0) begin
					busy_r <= 1'h0;
					done_o <= 1'h1;
					fail_o <= fail_en_i; // fail only with a finish
				end else begin
					cnt_r <= cnt_r - 4'h1;
				end
			end
		end
	end
endmodule : nsl_flash_model

/* tb/tb.sv */
`timescale 1ns/1ps

module tb;
	logic                  core_clk_i, srst_i, nvm_done_i, nvm_fail_i;
	logic                  array_access_i, sleep_enter_i, sleep_exit_i;
	logic                  security_i, ready_o, power_reduced_o, irq_o;
	logic                  fail_en;
	logic [3:0]            dly;
	logic [31:0]           rdata_o;
	logic [15:0]           region_lock_o;
	nsl_pkg::nsl_bus_t     bus_i;
	nsl_pkg::nsl_pbuf_t    pbuf_i;
	nsl_pkg::nsl_nvm_req_t nvm_req_o;
	int                    error_cnt, cmp_count;

	nsl_core dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .bus_i(bus_i),
		.rdata_o(rdata_o), .nvm_req_o(nvm_req_o), .nvm_done_i(nvm_done_i),
		.nvm_fail_i(nvm_fail_i), .pbuf_i(pbuf_i),
		.array_access_i(array_access_i), .sleep_enter_i(sleep_enter_i),
		.sleep_exit_i(sleep_exit_i), .security_i(security_i),
		.ready_o(ready_o), .power_reduced_o(power_reduced_o),
		.region_lock_o(region_lock_o), .irq_o(irq_o));

	nsl_flash_model flash_u (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.req_i(nvm_req_o), .dly_i(dly), .fail_en_i(fail_en),
		.done_o(nvm_done_i), .fail_o(nvm_fail_i));

	// free-running clock
	initial begin
		core_clk_i = 1'h0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : tick

	// each bus and load task returns 1 ns after the edge that took its request
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		bus_i <= '{1'h1, 1'h0, a, d};
		@(posedge core_clk_i);
		bus_i.wr <= 1'h0;
		#1;
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] exp);
		@(posedge core_clk_i);
		bus_i <= '{1'h0, 1'h1, a, 32'h0};
		@(posedge core_clk_i);
		bus_i.rd <= 1'h0;
		#1;
		chk(nm, rdata_o, exp);
	endtask : rdc

	task automatic cmd(input logic [15:0] w);
		wr(nsl_pkg::OFS_CMD, {16'h0, w});
	endtask : cmd

	task automatic load(input logic [21:0] a, input logic last);
		@(posedge core_clk_i);
		pbuf_i <= '{1'h1, last, a};
		@(posedge core_clk_i);
		pbuf_i.load <= 1'h0;
		#1;
	endtask : load

	// 0 array access, 1 sleep entry, 2 sleep exit
	task automatic pulse(input int k);
		@(posedge core_clk_i);
		array_access_i <= (k == 0);
		sleep_enter_i  <= (k == 1);
		sleep_exit_i   <= (k == 2);
		@(posedge core_clk_i);
		{array_access_i, sleep_enter_i, sleep_exit_i} <= 3'h0;
		tick(1);
	endtask : pulse

	// bounded wait, the model never takes more than 16 cycles
	task automatic wait_idle();
		int n;
		n = 0;
		while (ready_o !== 1'h1 && n < 100) begin
			tick(1);
			n++;
		end
		tick(1);
		chk("ready", {31'h0, ready_o}, 32'h1);
	endtask : wait_idle

	task automatic give_verdict();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	// hang guard, tests need a few hundred cycles
	initial begin
		#100000;
		error_cnt++;
		give_verdict();
	end

	initial begin
		error_cnt = 0;
		cmp_count = 0;
		srst_i = 1'h1;
		bus_i = '0;
		pbuf_i = '0;
		{array_access_i, sleep_enter_i, sleep_exit_i} = 3'h0;
		security_i = 1'h0;
		fail_en = 1'h0;
		dly = 4'h5;
		repeat (16) @(posedge core_clk_i);
		srst_i <= 1'h0;
		// reset values
		rdc("status", nsl_pkg::OFS_STATUS, 32'h0);
		rdc("addr", nsl_pkg::OFS_ADDR, 32'h0);
		rdc("lock", nsl_pkg::OFS_LOCK, 32'h0000FFFF);
		rdc("ctrl", nsl_pkg::OFS_CTRL, 32'h80);
		rdc("unmapped", 8'h3C, 32'h0);
		chk("ready", {31'h0, ready_o}, 32'h1);
		security_i <= 1'h1;
		wr(nsl_pkg::OFS_STATUS, 32'hFFFFFFFF);
		rdc("sec", nsl_pkg::OFS_STATUS, 32'h100);
		security_i <= 1'h0;
		wr(nsl_pkg::OFS_ADDR, 32'hFFFFFFFF);
		rdc("addr wide", nsl_pkg::OFS_ADDR, 32'h003FFFFF);
		// page write launch, prompt array
		dly = 4'h0;
		wr(nsl_pkg::OFS_ADDR, 32'h00000123);
		cmd(16'h3C02);
		chk("start", {31'h0, nvm_req_o.start}, 32'h1);
		chk("req addr", {10'h0, nvm_req_o.addr}, 32'h123);
		chk("busy", {31'h0, ready_o}, 32'h0);
		wait_idle();
		// erase row, slow array, with failure
		dly = 4'hC;
		fail_en = 1'h1;
		cmd(16'h3C01);
		chk("erase", {31'h0, nvm_req_o.erase}, 32'h1);
		wait_idle();
		fail_en = 1'h0;
		rdc("fail", nsl_pkg::OFS_STATUS, 32'h10);
		rdc("iflag", nsl_pkg::OFS_IFLAG, 32'h3);
		// interrupt masking and clearing
		chk("irq masked", {31'h0, irq_o}, 32'h0);
		wr(nsl_pkg::OFS_IMASK, 32'h2);
		tick(1);
		chk("irq on", {31'h0, irq_o}, 32'h1);
		wr(nsl_pkg::OFS_IFLAG, 32'h3);
		tick(1);
		chk("irq off", {31'h0, irq_o}, 32'h0);
		wr(nsl_pkg::OFS_STATUS, 32'h0);
		rdc("w0 keeps", nsl_pkg::OFS_STATUS, 32'h10);
		wr(nsl_pkg::OFS_STATUS, 32'h10);
		rdc("w1 clears", nsl_pkg::OFS_STATUS, 32'h0);
		// every code with a wrong key, then an unknown code
		for (int c = 1; c <= 9; c++) begin
			cmd((c == 9) ? 16'h3C7F : {8'h55, 1'h0, 7'(c)});
			rdc("bad cmd", nsl_pkg::OFS_STATUS, 32'h4);
			wr(nsl_pkg::OFS_STATUS, 32'h4);
		end
		rdc("lock kept", nsl_pkg::OFS_LOCK, 32'h0000FFFF);
		wr(nsl_pkg::OFS_IFLAG, 32'h3);
		// lock region 3, then try to program it
		dly = 4'h3;
		wr(nsl_pkg::OFS_ADDR, 32'h000C0000);
		cmd(16'h3C03);
		wait_idle();
		chk("lock out", {16'h0, region_lock_o}, 32'h0000FFF7);
		wr(nsl_pkg::OFS_LOCK, 32'h0);
		rdc("lock ro", nsl_pkg::OFS_LOCK, 32'h0000FFF7);
		wr(nsl_pkg::OFS_ADDR, 32'h000C0010);
		cmd(16'h3C02);
		chk("no start", {31'h0, nvm_req_o.start}, 32'h0);
		tick(1);
		chk("irq err", {31'h0, irq_o}, 32'h1);
		rdc("locked wr", nsl_pkg::OFS_STATUS, 32'h08);
		wr(nsl_pkg::OFS_STATUS, 32'h1F);
		cmd(16'h3C04);
		wait_idle();
		rdc("unlock", nsl_pkg::OFS_LOCK, 32'h0000FFFF);
		wr(nsl_pkg::OFS_ADDR, 32'h003C0000);
		cmd(16'h3C03);
		wait_idle();
		rdc("lock 15", nsl_pkg::OFS_LOCK, 32'h00007FFF);
		cmd(16'h3C08);
		wait_idle();
		rdc("erase locks", nsl_pkg::OFS_LOCK, 32'h0000FFFF);
		wr(nsl_pkg::OFS_IFLAG, 32'h3);
		// page buffer loads
		load(22'h000055, 1'h0);
		rdc("load addr", nsl_pkg::OFS_ADDR, 32'h55);
		rdc("loaded", nsl_pkg::OFS_STATUS, 32'h02);
		cmd(16'h3C07);
		wait_idle();
		rdc("buf clr", nsl_pkg::OFS_STATUS, 32'h0);
		load(22'h000040, 1'h0);
		wr(nsl_pkg::OFS_STATUS, 32'h02);
		rdc("load w1c", nsl_pkg::OFS_STATUS, 32'h0);
		load(22'h000080, 1'h0);
		cmd(16'h3C02);
		chk("pbuf addr", {10'h0, nvm_req_o.addr}, 32'h80);
		wait_idle();
		rdc("page wr", nsl_pkg::OFS_STATUS, 32'h0);
		wr(nsl_pkg::OFS_CTRL, 32'h0);
		load(22'h000099, 1'h1);
		chk("auto start", {31'h0, nvm_req_o.start}, 32'h1);
		chk("auto addr", {10'h0, nvm_req_o.addr}, 32'h99);
		wait_idle();
		// the last-word load itself wins over its own page write clear
		rdc("auto load", nsl_pkg::OFS_STATUS, 32'h02);
		wr(nsl_pkg::OFS_STATUS, 32'h02);
		// power reduction by command, access and sleep
		cmd(16'h3C05);
		wait_idle();
		rdc("prm cmd", nsl_pkg::OFS_STATUS, 32'h01);
		pulse(0);
		chk("prm access", {31'h0, power_reduced_o}, 32'h0);
		cmd(16'h3C05);
		wait_idle();
		cmd(16'h3C06);
		wait_idle();
		chk("prm clr", {31'h0, power_reduced_o}, 32'h0);
		wr(nsl_pkg::OFS_CTRL, {22'h0, nsl_pkg::SLP_WAKE_INSTANT, 8'h0});
		pulse(1);
		chk("slp enter", {31'h0, power_reduced_o}, 32'h1);
		pulse(2);
		chk("slp exit", {31'h0, power_reduced_o}, 32'h0);
		wr(nsl_pkg::OFS_CTRL, {22'h0, nsl_pkg::SLP_DISABLED, 8'h0});
		pulse(1);
		chk("slp off", {31'h0, power_reduced_o}, 32'h0);
		// wake on access: sleep exit must not end power reduction
		wr(nsl_pkg::OFS_CTRL, {22'h0, nsl_pkg::SLP_WAKE_ACCESS, 8'h0});
		pulse(1);
		chk("slp acc on", {31'h0, power_reduced_o}, 32'h1);
		pulse(2);
		chk("slp stay", {31'h0, power_reduced_o}, 32'h1);
		pulse(0);
		chk("slp access", {31'h0, power_reduced_o}, 32'h0);
		give_verdict();
	end
endmodule : tb
